/* File: aics_top.sv */
// Analog input configuration decode and traditional channel select.
// Assumes AXI4-Lite master on clk_in and an asynchronous sample-start pin.
`timescale 1ns/10ps
`default_nettype none

module aics_top (
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 sample_start_n_in,
  input  wire logic [3:0]           s_axi_awaddr_in,
  input  wire logic                 s_axi_awvalid_in,
  output logic                      s_axi_awready_out,
  input  wire logic [31:0]          s_axi_wdata_in,
  input  wire logic [3:0]           s_axi_wstrb_in,
  input  wire logic                 s_axi_wvalid_in,
  output logic                      s_axi_wready_out,
  output logic [1:0]                s_axi_bresp_out,
  output logic                      s_axi_bvalid_out,
  input  wire logic                 s_axi_bready_in,
  input  wire logic [3:0]           s_axi_araddr_in,
  input  wire logic                 s_axi_arvalid_in,
  output logic                      s_axi_arready_out,
  output logic [31:0]               s_axi_rdata_out,
  output logic [1:0]                s_axi_rresp_out,
  output logic                      s_axi_rvalid_out,
  input  wire logic                 s_axi_rready_in,
  output aics_pkg::aics_sel_t       mux_sel_out,
  output logic                      conv_start_out,
  output logic [11:0]               code_min_out,
  output logic [11:0]               code_max_out
);

  // Channel pair decode; odd lanes carry the negative of a pair when the address is even
  function automatic aics_pkg::aics_sel_t decode_sel(input aics_pkg::aics_ctrl_t c);
    aics_pkg::aics_sel_t s;
    s = '0;
    s.traditional = ~c.auto_cycle_bit & ~c.channel_list_bit;
    unique case ({c.input_config_bit0, c.input_config_bit1})
      aics_pkg::AICS_SINGLE_ENDED: begin
        s.pos_chan   = c.chan_addr;
        s.neg_is_gnd = 1'b1;
      end
      aics_pkg::AICS_FULLY_DIFF, aics_pkg::AICS_PSEUDO_PAIRS: begin
        // Pair index picks lanes 2n and 2n+1; address bit zero swaps polarity
        s.pos_chan = {c.chan_addr[2:1], c.chan_addr[0]};
        s.neg_chan = {c.chan_addr[2:1], ~c.chan_addr[0]};
      end
      aics_pkg::AICS_PSEUDO_SEVEN: begin
        // Address seven would select the common pin against itself; clamp
        s.pos_chan = (c.chan_addr == 3'h7) ? 3'h6 : c.chan_addr;
        s.neg_chan = 3'h7; // common_negative_input
      end
    endcase
    return s;
  endfunction

  // All state of the block
  typedef struct packed {
    logic [2:0]          start_sync;  // Three-stage sample-start synchroniser
    logic                start_level; // Filtered sample-start level
    aics_pkg::aics_ctrl_t ctrl;
    aics_pkg::aics_sel_t active;
    logic                conv_start;
    logic [15:0]         conv_count;
    logic [11:0]         code_min;
    logic [11:0]         code_max;
    logic                aw_held;
    logic [3:0]          aw_addr;
    logic                w_held;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
  } aics_state_t;

  aics_state_t st_reg;  // Registered state
  aics_state_t st_next; // Next state

  logic aw_take;  // Write address accepted this cycle
  logic w_take;   // Write data accepted this cycle
  logic ar_take;  // Read address accepted this cycle

  // Each write channel is ready only while its own half is not held and no response is pending
  assign aw_take = s_axi_awvalid_in & ~st_reg.aw_held & ~st_reg.bvalid;
  assign w_take  = s_axi_wvalid_in & ~st_reg.w_held & ~st_reg.bvalid;
  assign ar_take = s_axi_arvalid_in & ~st_reg.rvalid;

  // Next-state logic
  always_comb begin
    logic [3:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        fall;
    waddr   = 4'h0;
    wdata   = 32'h0000_0000;
    wstrb   = 4'h0;
    fall    = 1'b0;
    st_next = st_reg;
    st_next.conv_start = 1'b0;

    // Synchroniser; a change counts once stages two and three agree
    st_next.start_sync = {st_reg.start_sync[1:0], sample_start_n_in};
    if (st_reg.start_sync[2] == st_reg.start_sync[1]) begin
      st_next.start_level = st_reg.start_sync[2];
      fall = st_reg.start_level & ~st_reg.start_sync[2];
    end

    // Conversion start latches the stored selection
    if (fall) begin
      st_next.conv_start = 1'b1;
      st_next.active     = decode_sel(st_reg.ctrl);
      st_next.conv_count = st_reg.conv_count + 16'h0001;
      // Bottom and top of scale apply to every mode's span
      st_next.code_min   = aics_pkg::CODE_BOTTOM;
      st_next.code_max   = aics_pkg::CODE_TOP;
    end

    // Write channels, taken in either order
    if (aw_take) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr_in;
    end
    if (w_take) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata_in;
      st_next.w_strb = s_axi_wstrb_in;
    end
    if (st_reg.aw_held & st_reg.w_held) begin
      waddr = st_reg.aw_addr;
      wdata = st_reg.w_data;
      wstrb = st_reg.w_strb;
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      if (waddr == aics_pkg::CTRL_OFFSET) begin
        st_next.bresp = aics_pkg::RESP_OKAY;
        // Only a control write moves the stored channel; a conversion start copies it to the selection
        if (wstrb[0]) begin
          st_next.ctrl = aics_pkg::aics_ctrl_t'(wdata[6:0]);
        end
      end else begin
        st_next.bresp = aics_pkg::RESP_SLVERR;
      end
    end
    if (st_reg.bvalid & s_axi_bready_in) begin
      st_next.bvalid = 1'b0;
    end

    // Read channel
    if (ar_take) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = aics_pkg::RESP_OKAY;
      unique case (s_axi_araddr_in)
        aics_pkg::CTRL_OFFSET:   st_next.rdata = {25'h0, st_reg.ctrl};
        aics_pkg::ACTIVE_OFFSET: st_next.rdata = {24'h0, st_reg.active};
        aics_pkg::STATUS_OFFSET: st_next.rdata = {15'h0, st_reg.active.traditional,
                                                  st_reg.conv_count};
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = aics_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st_reg.rvalid & s_axi_rready_in) begin
      st_next.rvalid = 1'b0;
    end
  end

  // State register; reset loads constants only
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg             <= '0;
      st_reg.start_sync  <= 3'b111;
      st_reg.start_level <= 1'b1;
      st_reg.ctrl        <= aics_pkg::aics_ctrl_t'(aics_pkg::CTRL_RESET);
      st_reg.conv_count  <= aics_pkg::COUNT_RESET;
      st_reg.code_max    <= aics_pkg::CODE_TOP;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from state flops
  assign s_axi_awready_out = ~st_reg.aw_held & ~st_reg.bvalid;
  assign s_axi_wready_out  = ~st_reg.w_held & ~st_reg.bvalid;
  assign s_axi_bvalid_out  = st_reg.bvalid;
  assign s_axi_bresp_out   = st_reg.bresp;
  assign s_axi_arready_out = ~st_reg.rvalid;
  assign s_axi_rvalid_out  = st_reg.rvalid;
  assign s_axi_rresp_out   = st_reg.rresp;
  assign s_axi_rdata_out   = st_reg.rdata;
  assign mux_sel_out       = st_reg.active;
  assign conv_start_out    = st_reg.conv_start;
  assign code_min_out      = st_reg.code_min;
  assign code_max_out      = st_reg.code_max;

endmodule

`default_nettype wire

/* File: aics_pkg.sv */
// Package for the analog input configuration and channel select block.
// Assumes one 100 MHz clock domain; software reaches the block over AXI4-Lite.
// Operation
// - Config 0,1 gives four fully differential pairs
// - Config 1,0 four pseudo pairs; 1,1 seven
// - Seven-input mode references the last input
// - Both sequencer bits clear means traditional mode
// - Selected channel changes only at a conversion start, to the last control write
// - Differential span maps bottom to top of scale
// - Config 0,0 gives eight single-ended channels
// - Falling sample-start edge begins sampling the channel
package aics_pkg;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFFSET   = 4'h0; // Control: config, mode, address
  localparam logic [3:0] ACTIVE_OFFSET = 4'h4; // Selection latched at conversion
  localparam logic [3:0] STATUS_OFFSET = 4'h8; // Conversion count and traditional-mode flag

  // Control field positions
  localparam int CFG_BIT0_POS   = 0;
  localparam int CFG_BIT1_POS   = 1;
  localparam int AUTO_CYCLE_POS = 2;
  localparam int CHAN_LIST_POS  = 3;
  localparam int CHAN_ADDR_LSB  = 4;

  // Reset values
  localparam logic [6:0]  CTRL_RESET  = 7'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Full-scale code bounds for a differential span
  localparam logic [11:0] CODE_BOTTOM = 12'h000;
  localparam logic [11:0] CODE_TOP    = 12'hfff;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Input configuration modes
  typedef enum logic [1:0] {
    AICS_SINGLE_ENDED = 2'b00,
    AICS_FULLY_DIFF   = 2'b10,
    AICS_PSEUDO_PAIRS = 2'b01,
    AICS_PSEUDO_SEVEN = 2'b11
  } aics_cfg_t;

  // Control register contents
  typedef struct packed {
    logic [2:0] chan_addr;        // chan_addr_msb..chan_addr_lsb
    logic       channel_list_bit;
    logic       auto_cycle_bit;
    logic       input_config_bit1;
    logic       input_config_bit0;
  } aics_ctrl_t;

  // Mux selection handed to the analog front end
  typedef struct packed {
    logic [2:0] pos_chan;   // Positive input pin
    logic [2:0] neg_chan;   // Negative input pin
    logic       neg_is_gnd; // Negative tied to analog ground
    logic       traditional;
  } aics_sel_t;

endpackage

/* File: aics_host_model.sv */
// Host model that pulls the sample-start pin low once per request.
// Assumes the bench raises fire_in for one clock per conversion wanted.
`timescale 1ns/10ps
`default_nettype none
module aics_host_model (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic fire_in,
  output logic      sample_start_n_out
);
  logic [1:0] low_cnt_reg; // Clocks left with the pin low
  // Three low clocks clear the glitch filter with margin
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_cnt_reg <= 2'h0;
    end else if (fire_in) begin
      low_cnt_reg <= 2'h3;
    end else if (low_cnt_reg != 2'h0) begin
      low_cnt_reg <= low_cnt_reg - 2'h1;
    end
  end
  // Pin idles high between conversions
  assign sample_start_n_out = (low_cnt_reg == 2'h0);
endmodule
`default_nettype wire

/* File: aics_top_asserts.sv */
// Checker for the channel select block, bound onto its top module.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module aics_chk (
  input wire logic                clk_in,
  input wire logic                resetn_in,
  input wire logic                sample_start_n_in,
  input wire logic                s_axi_awvalid_in,
  input wire logic                s_axi_awready_out,
  input wire logic                s_axi_wvalid_in,
  input wire logic                s_axi_wready_out,
  input wire logic                s_axi_bvalid_out,
  input wire logic                s_axi_bready_in,
  input wire logic [1:0]          s_axi_bresp_out,
  input wire aics_pkg::aics_sel_t mux_sel_out,
  input wire logic                conv_start_out,
  input wire logic [11:0]         code_min_out,
  input wire logic [11:0]         code_max_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_code_span: assert property (
    code_min_out == aics_pkg::CODE_BOTTOM && code_max_out == aics_pkg::CODE_TOP)
    else $error("code span wrong");
  a_sel_hold: assert property (
    !conv_start_out |-> $stable(mux_sel_out)) else $error("selection moved without start");
  a_start_lat: assert property (
    $fell(sample_start_n_in) |-> ##[2:5] conv_start_out) else $error("start pulse late");
  a_one_pulse: assert property (
    conv_start_out |=> !conv_start_out) else $error("start pulse too long");
  a_pair_split: assert property (
    conv_start_out && !mux_sel_out.neg_is_gnd |-> mux_sel_out.pos_chan != mux_sel_out.neg_chan)
    else $error("pair uses one pin twice");
  a_b_hold: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  a_b_after: assert property (
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |-> ##2 s_axi_bvalid_out) else $error("write response missing");
  a_b_once: assert property (
    s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out) else $error("response repeated");
  cover property (conv_start_out && mux_sel_out.neg_chan == 3'h7);
  cover property (conv_start_out && mux_sel_out.neg_is_gnd);
  cover property (s_axi_bvalid_out && s_axi_bresp_out == aics_pkg::RESP_SLVERR);
endmodule
bind aics_top aics_chk u_aics_chk (.clk_in, .resetn_in, .sample_start_n_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_bresp_out, .mux_sel_out, .conv_start_out, .code_min_out, .code_max_out);
`default_nettype wire

/* File: tb_aics_top.sv */
// Bench: AXI4-Lite control writes, conversions and a sweep of all modes.
// Assumes the package, the design, its checker and the host model.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_aics_top;
  logic clk_in, resetn_in, sample_start_n_in, fire, s_axi_awvalid_in, s_axi_wvalid_in;
  logic s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out;
  logic s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, conv_start_out;
  logic [3:0]  s_axi_awaddr_in, s_axi_araddr_in, s_axi_wstrb_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  logic [11:0] code_min_out, code_max_out;
  aics_pkg::aics_sel_t mux_sel_out, exp_sel;
  int errors = 0;
  int checks = 0;
  aics_top u_aics_top (.clk_in, .resetn_in, .sample_start_n_in, .s_axi_awaddr_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .mux_sel_out, .conv_start_out, .code_min_out,
    .code_max_out);
  aics_host_model u_aics_host_model (.clk_in, .resetn_in, .fire_in(fire),
    .sample_start_n_out(sample_start_n_in));
  // One bus access; handshakes are read mid-cycle, away from the edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tw, tr;
    @(posedge clk_in);
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} <= {a, a, d};
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= {3{wr}};
    {s_axi_arvalid_in, s_axi_rready_in} <= {2{!wr}};
    forever begin
      @(negedge clk_in);
      if (wr ? s_axi_bvalid_out === 1'b1 : s_axi_rvalid_out === 1'b1) break;
      ta = s_axi_awvalid_in && s_axi_awready_out;
      tw = s_axi_wvalid_in && s_axi_wready_out;
      tr = s_axi_arvalid_in && s_axi_arready_out;
      @(posedge clk_in);
      if (ta) s_axi_awvalid_in <= 1'b0;
      if (tw) s_axi_wvalid_in <= 1'b0;
      if (tr) s_axi_arvalid_in <= 1'b0;
    end
    r = wr ? s_axi_bresp_out : s_axi_rresp_out;
    rd = s_axi_rdata_out;
    @(posedge clk_in);
    {s_axi_bready_in, s_axi_rready_in} <= 2'b00;
  endtask
  // Ask the host model for a conversion and wait for the start pulse
  task automatic conv();
    @(posedge clk_in);
    fire <= 1'b1;
    @(posedge clk_in);
    fire <= 1'b0;
    for (int n = 0; n < 12 && conv_start_out !== 1'b1; n++) @(negedge clk_in);
    `CHK(conv_start_out, 1'b1)
    repeat (6) @(posedge clk_in);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Sweep takes about 650 clocks; this leaves wide margin
  initial begin
    #200000;
    errors++;
    wrap_up();
  end
  initial begin
    logic [6:0] c;
    logic [7:0] m;
    logic [1:0] r;
    {resetn_in, fire, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 5'h00;
    {s_axi_arvalid_in, s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in} = 10'h000;
    {s_axi_wdata_in, s_axi_wstrb_in, exp_sel, m} = {32'h0000_0000, 4'hf, 8'h00, 8'hff};
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    `CHK(mux_sel_out, 8'h00)
    `CHK({code_min_out, code_max_out}, {aics_pkg::CODE_BOTTOM, aics_pkg::CODE_TOP})
    $display("test reset done");
    // Every config and sequencer bit pair, odd and even addresses, address 7
    for (int i = 0; i < 16; i++) begin
      c = {3'(i + 4), 4'(i)};
      bus(1'b1, aics_pkg::CTRL_OFFSET, {25'h000_0000, c}, r);
      `CHK(r, aics_pkg::RESP_OKAY)
      repeat (4) @(negedge clk_in);
      `CHK(mux_sel_out & m, exp_sel & m)
      bus(1'b0, aics_pkg::CTRL_OFFSET, 32'h0000_0000, r);
      `CHK(rd[6:0], c)
      exp_sel.pos_chan = (c[1:0] == 2'b11 && c[6:4] == 3'h7) ? 3'h6 : c[6:4];
      exp_sel.neg_chan = (c[1:0] == 2'b11) ? 3'h7 : c[6:4] ^ 3'h1;
      exp_sel.neg_is_gnd = (c[1:0] == 2'b00);
      exp_sel.traditional = (c[3:2] == 2'b00);
      m = exp_sel.neg_is_gnd ? 8'he3 : 8'hff;
      conv();
      `CHK(mux_sel_out & m, exp_sel & m)
      bus(1'b0, aics_pkg::ACTIVE_OFFSET, 32'h0000_0000, r);
      `CHK(rd[7:0] & m, exp_sel & m)
      conv();
      `CHK(mux_sel_out & m, exp_sel & m)
    end
    $display("test sweep done");
    // Unmapped place: refused both ways, selection untouched
    bus(1'b1, 4'hc, 32'h0000_007f, r);
    `CHK(r, aics_pkg::RESP_SLVERR)
    bus(1'b0, 4'hc, 32'h0000_0000, r);
    `CHK({r, rd}, {aics_pkg::RESP_SLVERR, 32'h0000_0000})
    conv();
    `CHK(mux_sel_out & m, exp_sel & m)
    bus(1'b0, aics_pkg::STATUS_OFFSET, 32'h0000_0000, r);
    `CHK({r, rd}, {aics_pkg::RESP_OKAY, 15'h0000, exp_sel.traditional, 16'h0021})
    $display("test refuse done");
    wrap_up();
  end
endmodule
`default_nettype wire
